// ### tb/sar_adc_convert_read_control_tb_top.sv
module sar_adc_convert_read_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sar_ctrl_pkg::*;
  logic clk_sys = 0, arst_n = 0, sel_n = 1, start_n = 1, rd_n = 1, pd_n = 1, bip = 0, cmp, busy_n;
  logic pd_flag, wake, sv;
  word_t target = 0, dac, res, oe_n, sd;
  int num_errors = 0, checked = 0;
  always #2.5 clk_sys = ~clk_sys;
  sar_adc_convert_read_control #(.CONV_CYCLES(24)) uut (.clk_sys, .arst_n, .device_select_n(sel_n),
    .conversion_start_n(start_n), .read_strobe_n(rd_n), .power_down_n(pd_n), .bipolar_mode(bip),
    .comparator_high(cmp), .dac_code(dac), .busy_n, .powered_down(pd_flag), .waking(wake),
    .result_bits_out(res), .result_bits_oe_n(oe_n), .stream_data(sd), .stream_valid(sv),
    .stream_ready(1'b1));
  sar_comparator cmp_i (.dac_code(dac), .target, .comparator_high(cmp));
  task automatic chk(string name, word_t exp, word_t got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s exp %h seen %h", name, exp, got);
    end
  endtask
  task automatic pulse_start();
    @(negedge clk_sys) start_n = 0;
    @(negedge clk_sys) start_n = 1;
  endtask
  task automatic read_word(word_t exp);
    @(negedge clk_sys) rd_n = 0;
    @(negedge clk_sys) chk("oe_n", 12'h000, oe_n);
    chk("result", exp, res);
    rd_n = 1;
  endtask
  task automatic t_conv(word_t t, logic b);
    int n;
    target = t;
    bip = b;
    sel_n = 0;
    pulse_start();
    chk("busy_n", 12'h000, {11'h0, busy_n});
    repeat (5) @(negedge clk_sys);
    pulse_start();
    n = 0;
    while (busy_n !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    // Start taken 8 negedges before the loop, which also counts the first high sample; 24 bit cycles plus the done cycle
    chk("conv_len", 12'd25, 12'(n + 7));
    read_word(b ? t ^ 12'h800 : t);
    chk("stream_valid", 12'h001, {11'h0, sv});
    chk("stream_data", b ? t ^ 12'h800 : t, sd);
    read_word(b ? t ^ 12'h800 : t);
    chk("stream_valid", 12'h000, {11'h0, sv});
    sel_n = 1;
    repeat (32) @(negedge clk_sys);
  endtask
  task automatic t_refused();
    pulse_start();
    chk("busy_n", 12'h001, {11'h0, busy_n});
    @(negedge clk_sys) rd_n = 0;
    @(negedge clk_sys) chk("oe_n", 12'hfff, oe_n);
    rd_n = 1;
    sel_n = 0;
    pd_n = 0;
    repeat (2) @(negedge clk_sys);
    chk("powered_down", 12'h001, {11'h0, pd_flag});
    pulse_start();
    chk("busy_n", 12'h001, {11'h0, busy_n});
    pd_n = 1;
    // Wake-up lasts 350 ns, 70 cycles
    repeat (60) @(negedge clk_sys);
    chk("powered_down", 12'h000, {11'h0, pd_flag});
    chk("waking", 12'h001, {11'h0, wake});
    repeat (20) @(negedge clk_sys);
    chk("waking", 12'h000, {11'h0, wake});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk_sys);
    arst_n = 1;
    repeat (3) @(negedge clk_sys);
    t_conv(12'ha5c, 0);
    t_conv(12'hfff, 1);
    t_conv(12'h000, 0);
    t_refused();
    t_conv(12'h3c1, 1);
    tally_and_finish();
  end
  initial begin
    #20000;
    num_errors++;
    tally_and_finish();
  end
endmodule

// ### tb/sar_comparator.sv
module sar_comparator (
  input wire sar_ctrl_pkg::word_t dac_code,
  input wire sar_ctrl_pkg::word_t target,
  output logic comparator_high
);
  timeunit 1ns;
  timeprecision 1ps;
  // Ideal comparator, input held as a code
  assign comparator_high = (dac_code <= target);
endmodule

// ### tb/sar_ctrl_sva.sv
module sar_ctrl_checker (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic device_select_n,
  input wire logic conversion_start_n,
  input wire logic read_strobe_n,
  input wire logic power_down_n,
  input wire sar_ctrl_pkg::word_t dac_code,
  input wire logic busy_n,
  input wire logic powered_down,
  input wire sar_ctrl_pkg::word_t result_bits_out,
  input wire sar_ctrl_pkg::word_t result_bits_oe_n,
  input wire logic stream_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  import sar_ctrl_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Bounds assume the short conversion of 2 cycles per bit
  sequence s_conv_run;
    ##1 (!busy_n)[*8] ##[11:19] $rose(busy_n);
  endsequence
  a_start_busy: assert property (
    $fell(conversion_start_n) && !device_select_n && power_down_n && busy_n && !stream_valid |=> !busy_n)
    else $error("start not taken");
  a_desel_start: assert property (
    $fell(conversion_start_n) && device_select_n && busy_n |=> busy_n) else $error("deselected start taken");
  a_pd_start: assert property (
    $fell(conversion_start_n) && !power_down_n && busy_n |=> busy_n) else $error("start taken in power-down");
  a_pd_flag: assert property (
    !power_down_n [*2] |-> powered_down) else $error("power-down not entered");
  a_oe_follow: assert property (
    1 |=> result_bits_oe_n == {12{$past(read_strobe_n | device_select_n)}}) else $error("output enable wrong");
  a_msb_first: assert property (
    $fell(busy_n) |-> dac_code == 12'h800) else $error("first trial not MSB");
  a_conv_len: assert property (
    $fell(busy_n) |-> s_conv_run) else $error("conversion length wrong");
  a_result_hold: assert property (
    !$rose(busy_n) |-> $stable(result_bits_out)) else $error("result changed outside completion");
  a_stream_push: assert property (
    $rose(busy_n) |-> ##[1:3] stream_valid) else $error("result not queued");
endmodule
bind sar_adc_convert_read_control sar_ctrl_checker chk_i (.clk_sys, .arst_n, .device_select_n,
  .conversion_start_n, .read_strobe_n, .power_down_n, .dac_code, .busy_n, .powered_down,
  .result_bits_out, .result_bits_oe_n, .stream_valid);

// ### verilog/result_fifo.sv
module result_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
    $error("DEPTH must be a power of two >= 2");
  end
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
    logic [WIDTH-1:0] dout;
    logic dvalid;
  } fifo_s;
  fifo_s s_reg;
  fifo_s s_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full;
  logic empty;
  logic push;
  logic pop;
  always_comb begin
    full = (s_reg.wr[AW] != s_reg.rd[AW]) && (s_reg.wr[AW-1:0] == s_reg.rd[AW-1:0]);
    empty = (s_reg.wr == s_reg.rd);
    in_ready = !full;
    push = in_valid && !full;
    // Output register refills whenever it is empty or being taken
    pop = !empty && (!s_reg.dvalid || out_ready);
    s_next = s_reg;
    if (push) s_next.wr = s_reg.wr + 1'b1;
    if (s_reg.dvalid && out_ready) s_next.dvalid = 1'b0;
    if (pop) begin
      s_next.rd = s_reg.rd + 1'b1;
      s_next.dout = mem[s_reg.rd[AW-1:0]];
      s_next.dvalid = 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (push) mem[s_reg.wr[AW-1:0]] <= in_data;
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) s_reg <= '0;
    else s_reg <= s_next;
  end
  assign out_data = s_reg.dout;
  assign out_valid = s_reg.dvalid;
endmodule

// ### verilog/sar_adc_convert_read_control.sv
// Functional notes
// [R1] Falling start edge begins a conversion; code refuses it while the stream buffer is full
// [R2] Start edge acted on only while selected
// [R3] Result driven only when read and selected
// [R4] Start and read ignored while deselected
// [R5] Busy low throughout conversion, high otherwise
// [R6] Power-down input low enters power-down
// [R7] Twelve result bits, top bit is MSB
// [R8] Approximation register cleared at conversion start
// [R9] Running conversion cannot be restarted
// [R10] Bits decided MSB first down to LSB
// [R11] Host allows 160 ns acquisition between conversions
// [R12] Completed word copied into output latches
// [R13] No conversion starts while powered down
// [R14] Host waits 350 ns wake-up before start
// [R15] Self-timed conversion takes about 1.4 us
// [R16] Binary unipolar, two's complement bipolar
// [R17] Busy rises only after result latched
// [R18] Latches hold result until next completion
`include "sar_ctrl_cfg.svh"
module sar_adc_convert_read_control #(
  parameter int CONV_CYCLES = `CONV_CYCLES,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic device_select_n,
  input wire logic conversion_start_n,
  input wire logic read_strobe_n,
  input wire logic power_down_n,
  input wire logic bipolar_mode,
  input wire logic comparator_high,
  output sar_ctrl_pkg::word_t dac_code,
  output logic busy_n,
  output logic powered_down,
  output logic waking,
  output sar_ctrl_pkg::word_t result_bits_out,
  output sar_ctrl_pkg::word_t result_bits_oe_n,
  output sar_ctrl_pkg::word_t stream_data,
  output logic stream_valid,
  input wire logic stream_ready
);
  import sar_ctrl_pkg::*;
  localparam int W = `RESULT_WIDTH;
  localparam int STEP = CONV_CYCLES / W;
  localparam int SW = $clog2(STEP + 1);
  localparam int WK = `WAKE_CYCLES;
  localparam int WKW = $clog2(WK + 1);
  // Refused at elaboration: every bit needs at least one cycle
  if (STEP < 1) begin : g_step_check
    $error("CONV_CYCLES too small for one cycle per bit");
  end

  typedef struct packed {
    conv_state_e state;
    logic start_n_d;
    word_t sar;
    logic [3:0] bit_idx;
    logic [SW-1:0] step_cnt;
    word_t latch;
    logic busy_n;
    logic pd;
    logic [WKW-1:0] wake_cnt;
    logic waking;
    word_t dout;
    word_t oe_n;
    logic push;
  } ctrl_s;

  ctrl_s s_reg;
  ctrl_s s_next;
  logic fifo_in_ready;
  logic fifo_out_valid;
  word_t fifo_out_data;

  // Raw comparator word in unipolar form; bipolar flips the MSB
  function automatic word_t format_word(input word_t raw, input logic bip);
    format_word = bip ? {~raw[W-1], raw[W-2:0]} : raw; // [R16]
  endfunction

  logic start_edge;
  always_comb begin
    s_next = s_reg;
    s_next.start_n_d = conversion_start_n;
    s_next.push = 1'b0;
    start_edge = s_reg.start_n_d && !conversion_start_n && !device_select_n; // [R1] [R2] [R4]

    s_next.pd = !power_down_n; // [R6]
    if (!power_down_n) begin
      s_next.wake_cnt = WKW'(WK);
    end else if (s_reg.wake_cnt != '0) begin
      s_next.wake_cnt = s_reg.wake_cnt - 1'b1;
    end
    // Registered so the pin comes straight from a flop
    s_next.waking = (s_next.wake_cnt != '0);

    case (s_reg.state)
      ST_IDLE: begin
        // Start refused while powered down; a full stream buffer also refuses it
        if (start_edge && power_down_n && fifo_in_ready) begin // [R13]
          s_next.state = ST_CONV;
          s_next.sar = {1'b1, {(W-1){1'b0}}}; // [R8]
          s_next.bit_idx = 4'(W - 1);
          s_next.step_cnt = SW'(STEP - 1);
          s_next.busy_n = 1'b0; // [R5]
        end
      end
      ST_CONV: begin
        // Further start edges are simply not looked at here
        if (s_reg.step_cnt != '0) begin // [R9] [R15]
          s_next.step_cnt = s_reg.step_cnt - 1'b1;
        end else begin
          if (!comparator_high) s_next.sar[s_reg.bit_idx] = 1'b0; // [R10]
          if (s_reg.bit_idx == 4'd0) begin
            s_next.state = ST_DONE;
          end else begin
            s_next.sar[s_reg.bit_idx - 4'd1] = 1'b1;
            s_next.bit_idx = s_reg.bit_idx - 4'd1;
            s_next.step_cnt = SW'(STEP - 1);
          end
        end
      end
      ST_DONE: begin
        s_next.latch = format_word(s_reg.sar, bipolar_mode); // [R12] [R7]
        s_next.push = 1'b1;
        s_next.state = ST_IDLE;
        s_next.busy_n = 1'b1; // [R17]
      end
      default: begin
        s_next.state = ST_IDLE;
        s_next.busy_n = 1'b1;
      end
    endcase

    // Latch changes only in ST_DONE, so reads repeat the word
    s_next.dout = s_next.latch; // [R18]
    s_next.oe_n = (!read_strobe_n && !device_select_n) ? '0 : '1; // [R3] [R4]
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
      s_reg.state <= ST_IDLE;
      s_reg.start_n_d <= 1'b1;
      s_reg.busy_n <= 1'b1;
      s_reg.oe_n <= '1;
    end else begin
      s_reg <= s_next;
    end
  end

  result_fifo #(
    .WIDTH(W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_data(s_reg.latch),
    .in_valid(s_reg.push),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(stream_ready)
  );

  assign dac_code = s_reg.sar;
  assign busy_n = s_reg.busy_n;
  assign powered_down = s_reg.pd;
  assign waking = s_reg.waking;
  assign result_bits_out = s_reg.dout;
  assign result_bits_oe_n = s_reg.oe_n;
  assign stream_data = fifo_out_data;
  assign stream_valid = fifo_out_valid;
endmodule

// ### verilog/sar_ctrl_cfg.svh
`ifndef SAR_CTRL_CFG_SVH
`define SAR_CTRL_CFG_SVH
`define CLK_PERIOD_PS 5000
`define CONV_TIME_NS 1400
`define CONV_CYCLES ((`CONV_TIME_NS * 1000) / `CLK_PERIOD_PS)
`define RESULT_WIDTH 12
`define FIFO_DEPTH 8
`define WAKE_TIME_NS 350
`define WAKE_CYCLES ((`WAKE_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`endif

// ### verilog/sar_ctrl_pkg.sv
`include "sar_ctrl_cfg.svh"
package sar_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_DONE = 2'b10
  } conv_state_e;
  typedef logic [`RESULT_WIDTH-1:0] word_t;
endpackage
